// >>> verilog/udpwm_action_gen.sv
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "udpwm_params.svh"
module udpwm_action_gen (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             pwmOutA,
  output logic             pwmOutB,
  output logic             countDir
);
  // ==========================================
  // Register file
  logic [31:0]               ctrl;
  logic [15:0]               periodValue;
  logic [15:0]               cmpAShadow;
  logic [15:0]               cmpBShadow;
  logic [15:0]               cmpAActive;
  logic [15:0]               cmpBActive;
  udpwm_pkg::udpwm_actset_t  actA;
  udpwm_pkg::udpwm_actset_t  actB;
  logic [15:0]               timebaseCount;
  logic                      tbTick;
  logic [7:0]                divCount;
  logic                      setup;
  logic                      wrEn;
  logic                      atZero;
  udpwm_pkg::udpwm_mode_t    mode;
  logic                      shdwA;
  logic                      shdwB;

  assign setup  = psel && !penable;
  // Access phase completes every time, one wait-free cycle
  assign wrEn   = psel && penable && pwrite;
  assign mode   = udpwm_pkg::udpwm_mode_t'(ctrl[`UDPWM_CTRL_MODE_LSB +: 2]);
  assign shdwA  = ctrl[`UDPWM_CTRL_SHDWA_BIT];
  assign shdwB  = ctrl[`UDPWM_CTRL_SHDWB_BIT];
  assign atZero = tbTick && (timebaseCount == 16'h0000);

  // ==========================================
  // APB slave: ready after setup, error on unmapped address
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      if (setup) begin
        if (paddr == `UDPWM_OFS_CTRL) begin
          prdata <= ctrl;
        end else if (paddr == `UDPWM_OFS_PERIOD) begin
          prdata <= {16'h0000, periodValue};
        end else if (paddr == `UDPWM_OFS_COMPARE_A_VALUE) begin
          prdata <= {16'h0000, cmpAActive};
        end else if (paddr == `UDPWM_OFS_COMPARE_B_VALUE) begin
          prdata <= {16'h0000, cmpBActive};
        end else if (paddr == `UDPWM_OFS_ACTA) begin
          prdata <= {20'h0_0000, actA};
        end else if (paddr == `UDPWM_OFS_ACTB) begin
          prdata <= {20'h0_0000, actB};
        end else if (paddr == `UDPWM_OFS_STATUS) begin
          prdata <= {13'h0000, countDir, pwmOutB, pwmOutA, timebaseCount};
        end else begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Control, period and action writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl        <= `UDPWM_RST_CTRL;
      periodValue <= `UDPWM_RST_PERIOD;
      actA        <= `UDPWM_RST_ACT;
      actB        <= `UDPWM_RST_ACT;
    end else if (wrEn && pready) begin
      if (paddr == `UDPWM_OFS_CTRL) begin
        ctrl <= {20'h0_0000, pwdata[11:0]};
      end else if (paddr == `UDPWM_OFS_PERIOD) begin
        periodValue <= pwdata[15:0];
      end else if (paddr == `UDPWM_OFS_ACTA) begin
        actA <= pwdata[11:0];
      end else if (paddr == `UDPWM_OFS_ACTB) begin
        actB <= pwdata[11:0];
      end
    end
  end

  // Compare shadows; active copy loads at zero, a same-cycle write skips that load
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmpAShadow <= `UDPWM_RST_CMP;
      cmpBShadow <= `UDPWM_RST_CMP;
      cmpAActive <= `UDPWM_RST_CMP;
      cmpBActive <= `UDPWM_RST_CMP;
    end else begin
      if (wrEn && pready && paddr == `UDPWM_OFS_COMPARE_A_VALUE) begin
        cmpAShadow <= pwdata[15:0];
        if (!shdwA) begin
          cmpAActive <= pwdata[15:0];
        end
      end else if (shdwA && atZero) begin
        cmpAActive <= cmpAShadow;
      end
      if (wrEn && pready && paddr == `UDPWM_OFS_COMPARE_B_VALUE) begin
        cmpBShadow <= pwdata[15:0];
        if (!shdwB) begin
          cmpBActive <= pwdata[15:0];
        end
      end else if (shdwB && atZero) begin
        cmpBActive <= cmpBShadow;
      end
    end
  end

  // ==========================================
  // Time-base clock enable from system clock divider
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      divCount <= 8'h00;
      tbTick   <= 1'b0;
    end else if (divCount >= ctrl[`UDPWM_CTRL_DIV_LSB +: 8]) begin
      divCount <= 8'h00;
      tbTick   <= 1'b1;
    end else begin
      divCount <= divCount + 8'h01;
      tbTick   <= 1'b0;
    end
  end

  // Counter: up wraps after period, up-down turns at period and zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timebaseCount <= 16'h0000;
      countDir      <= 1'b1;
    end else if (tbTick) begin
      case (mode)
        udpwm_pkg::UD_MODE_UP: begin
          countDir <= 1'b1;
          if (timebaseCount >= periodValue) begin
            timebaseCount <= 16'h0000;
          end else begin
            timebaseCount <= timebaseCount + 16'h0001;
          end
        end
        udpwm_pkg::UD_MODE_DOWN: begin
          countDir <= 1'b0;
          if (timebaseCount == 16'h0000) begin
            timebaseCount <= periodValue;
          end else begin
            timebaseCount <= timebaseCount - 16'h0001;
          end
        end
        udpwm_pkg::UD_MODE_UPDOWN: begin
          // Full cycle is two times period ticks
          if (countDir && timebaseCount >= periodValue) begin
            countDir      <= 1'b0;
            timebaseCount <= timebaseCount - 16'h0001;
          end else if (!countDir && timebaseCount == 16'h0000) begin
            countDir      <= 1'b1;
            timebaseCount <= timebaseCount + 16'h0001;
          end else if (countDir) begin
            timebaseCount <= timebaseCount + 16'h0001;
          end else begin
            timebaseCount <= timebaseCount - 16'h0001;
          end
        end
        default: begin
          timebaseCount <= timebaseCount;
        end
      endcase
    end
  end

  // ==========================================
  // Action qualifier: later events in list win (compare over zero/period)
  function automatic logic applyAct(input logic cur,
                                    input udpwm_pkg::udpwm_actset_t a,
                                    input logic isZero,
                                    input logic isPrd,
                                    input logic hitA,
                                    input logic hitB,
                                    input logic up);
    logic v;
    v = cur;
    if (isZero) v = doAct(v, a.zeroEvt);
    if (isPrd) v = doAct(v, a.periodEvt);
    if (hitA && up) v = doAct(v, a.cmpAUp);
    if (hitA && !up) v = doAct(v, a.cmpADown);
    if (hitB && up) v = doAct(v, a.cmpBUp);
    if (hitB && !up) v = doAct(v, a.cmpBDown);
    return v;
  endfunction

  function automatic logic doAct(input logic cur, input udpwm_pkg::udpwm_act_t act);
    case (act)
      udpwm_pkg::UD_ACT_CLEAR:  return 1'b0;
      udpwm_pkg::UD_ACT_SET:    return 1'b1;
      udpwm_pkg::UD_ACT_TOGGLE: return !cur;
      default:                  return cur;
    endcase
  endfunction

  // Outputs evaluated per tick on the count held in that tick
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwmOutA <= 1'b0;
      pwmOutB <= 1'b0;
    end else if (tbTick && mode != udpwm_pkg::UD_MODE_STOP) begin
      // behaviour follows from per-direction compare actions
      pwmOutA <= applyAct(pwmOutA, actA, timebaseCount == 16'h0000,
                          timebaseCount == periodValue, timebaseCount == cmpAActive,
                          timebaseCount == cmpBActive, countDir);
      pwmOutB <= applyAct(pwmOutB, actB, timebaseCount == 16'h0000,
                          timebaseCount == periodValue, timebaseCount == cmpAActive,
                          timebaseCount == cmpBActive, countDir);
    end
  end
endmodule // udpwm_action_gen

// >>> pkg/udpwm_params.svh
`ifndef UDPWM_PARAMS_SVH
`define UDPWM_PARAMS_SVH
// Contract
// - In up-down mode one output cycle lasts two times the period value in time-base clocks.
// - A set on compare-A up and cleared on compare-A down gives a symmetric low pulse set by compare A.
// - B cleared on compare-B up and set on compare-B down gives a symmetric high pulse set by compare B.
// - In the complementary setup the edge gap of A and B equals compare B minus compare A.
// - For asymmetric placement A is set on compare-A up and cleared on compare-B down.
// - In the asymmetric setup the low time of A follows the sum of compare A and compare B.
// - B cleared on zero and set on period gives a fixed half-duty square wave.
// - In up mode the counter wraps to zero the time-base clock after it reaches the period.

// Register byte offsets
`define UDPWM_OFS_CTRL    12'h000
`define UDPWM_OFS_PERIOD  12'h004
`define UDPWM_OFS_COMPARE_A_VALUE    12'h008
`define UDPWM_OFS_COMPARE_B_VALUE    12'h00C
`define UDPWM_OFS_ACTA    12'h010
`define UDPWM_OFS_ACTB    12'h014
`define UDPWM_OFS_STATUS  12'h018
// Control fields
`define UDPWM_CTRL_MODE_LSB   0
`define UDPWM_CTRL_SHDWA_BIT  2
`define UDPWM_CTRL_SHDWB_BIT  3
`define UDPWM_CTRL_DIV_LSB    4
// Action fields, two bits each
`define UDPWM_ACT_ZERO_LSB  0
`define UDPWM_ACT_PRD_LSB   2
`define UDPWM_ACT_CAU_LSB   4
`define UDPWM_ACT_CAD_LSB   6
`define UDPWM_ACT_CBU_LSB   8
`define UDPWM_ACT_CBD_LSB   10
// Reset values
`define UDPWM_RST_CTRL    32'h0000_000F
`define UDPWM_RST_PERIOD  16'h0000
`define UDPWM_RST_CMP     16'h0000
`define UDPWM_RST_ACT     12'h000
`define UDPWM_UPDOWN_FACTOR 2
`endif

// >>> pkg/udpwm_pkg.sv
package udpwm_pkg;
  typedef enum logic [1:0] {
    UD_MODE_UP,
    UD_MODE_DOWN,
    UD_MODE_UPDOWN,
    UD_MODE_STOP
  } udpwm_mode_t;
  typedef enum logic [1:0] {
    UD_ACT_NONE,
    UD_ACT_CLEAR,
    UD_ACT_SET,
    UD_ACT_TOGGLE
  } udpwm_act_t;
  typedef struct packed {
    udpwm_act_t cmpBDown;
    udpwm_act_t cmpBUp;
    udpwm_act_t cmpADown;
    udpwm_act_t cmpAUp;
    udpwm_act_t periodEvt;
    udpwm_act_t zeroEvt;
  } udpwm_actset_t;
endpackage

// >>> sim/udpwm_gate_model.sv
`timescale 1ns/1ps
// ==========================================
// Gate driver model: times each output level
module udpwm_gate_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        gateA,
  input  wire logic        gateB,
  output logic      [15:0] hiA,
  output logic      [15:0] loA,
  output logic      [15:0] hiB,
  output logic      [15:0] loB,
  output logic      [15:0] gapAB
);
  logic [15:0] runA, runB, runGap;
  logic        prevA, prevB;
  // Last finished pulse widths in clocks; a driver only sees levels
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {runA, runB, runGap, hiA, loA, hiB, loB, gapAB} <= '0;
      {prevA, prevB} <= 2'b00;
    end else begin
      prevA <= gateA;
      prevB <= gateB;
      runA <= (gateA != prevA) ? 16'h0001 : runA + 16'h0001;
      runB <= (gateB != prevB) ? 16'h0001 : runB + 16'h0001;
      runGap <= (gateA && !prevA) ? 16'h0001 : runGap + 16'h0001;
      if (gateA != prevA) begin
        if (prevA) hiA <= runA; else loA <= runA;
      end
      if (gateB != prevB) begin
        if (prevB) hiB <= runB; else loB <= runB;
      end
      if (!gateB && prevB) gapAB <= runGap; // Edge spacing A rise to B fall
    end
  end
endmodule // udpwm_gate_model

// >>> sim/udpwm_action_gen_props.sv
`timescale 1ns/1ps
// ==========================================
// Bus answer and status checks
module udpwm_action_gen_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pwmOutA,
  input wire logic        pwmOutB,
  input wire logic        countDir
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
    else $error("answer held too long");
  AST_READY_CAUSE: assert property (pready |-> $past(psel && !penable))
    else $error("answer without setup");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("answer outside access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without answer");
  AST_UNMAPPED: assert property (psel && !penable && !pwrite && paddr > 12'h018
    |=> pslverr && prdata == 32'h0000_0000) else $error("unmapped read not refused");
  AST_MAPPED: assert property (psel && !penable && paddr <= 12'h018
    && paddr[1:0] == 2'b00 |=> !pslverr) else $error("mapped access refused");
  AST_STATUS_LIVE: assert property (psel && !penable && !pwrite && paddr == 12'h018
    |=> prdata[18:16] == $past({countDir, pwmOutB, pwmOutA})) else $error("status stale");
endmodule // udpwm_action_gen_props
bind udpwm_action_gen udpwm_action_gen_props u_props (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pwmOutA(pwmOutA), .pwmOutB(pwmOutB),
  .countDir(countDir));

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int P = 20;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, rdErr;
  logic        pwmOutA, pwmOutB, countDir;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] hiA, loA, hiB, loB, gapAB;
  int          err_total, n_checks, cycles;
  // ==========================================
  // Clock, design and gate model
  always #5 mclk = ~mclk;
  udpwm_action_gen u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwmOutA(pwmOutA), .pwmOutB(pwmOutB), .countDir(countDir));
  udpwm_gate_model u_gate (.mclk(mclk), .rst(rst), .gateA(pwmOutA), .gateB(pwmOutB),
    .hiA(hiA), .loA(loA), .hiB(hiB), .loB(loB), .gapAB(gapAB));
  // Hang guard, far above the roughly 1300 cycles needed
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // ==========================================
  // Shared tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask
  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // Program a waveform, then let several cycles complete
  task automatic setup(input logic [31:0] c, ac, bc, input logic [15:0] ca, cb);
    apb(1'b1, 12'h004, P);
    apb(1'b1, 12'h008, {16'h0000, ca});
    apb(1'b1, 12'h00C, {16'h0000, cb});
    apb(1'b1, 12'h010, ac);
    apb(1'b1, 12'h014, bc);
    apb(1'b1, 12'h000, c);
    repeat (6 * P) @(posedge mclk);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd_chk(12'h000, 32'h0000_000F);
    rd_chk(12'h004, 32'h0000_0000);
    rd_chk(12'h014, 32'h0000_0000);
    rd_chk(12'h018, 32'h0004_0000);
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    chk(32'(rdErr), 32'h0000_0001);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk(32'(rdErr), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
  endtask
  task automatic t_sym();
    setup(32'h0E, 32'h060, 32'h900, 16'h0008, 16'h000C);
    chk(32'(hiA + loA), 2 * P);
    chk(32'(loA), 16);
    chk(32'(hiB), 24);
    chk(32'(loB), 2 * (P - 12));
    chk(32'(gapAB), 4);
    // Direction seen one edge after A rises, then status read while falling
    @(posedge pwmOutA);
    @(posedge mclk);
    chk(32'(countDir), 32'h0000_0001);
    @(negedge pwmOutA);
    rd_chk(12'h018, 32'h0002_0006);
  endtask
  // Compare write lands at the next zero with shadow on (far from zero here), at once with it off
  task automatic t_shadow();
    @(posedge pwmOutA);
    apb(1'b1, 12'h008, 32'h0000_0005);
    rd_chk(12'h008, 32'h0000_0008);
    repeat (6 * P) @(posedge mclk);
    rd_chk(12'h008, 32'h0000_0005);
    chk(32'(loA), 10);
    apb(1'b1, 12'h000, 32'h0000_0002);
    apb(1'b1, 12'h008, 32'h0000_0009);
    rd_chk(12'h008, 32'h0000_0009);
  endtask
  task automatic t_asym();
    setup(32'h0E, 32'h420, 32'h009, 16'h0004, 16'h000E);
    chk(32'(loA), 18);
    chk(32'(hiA), 22);
    chk(32'(hiB), P);
    chk(32'(loB), P);
    setup(32'h0E, 32'h810, 32'h009, 16'h0004, 16'h000E);
    chk(32'(hiA), 18);
  endtask
  task automatic t_up();
    setup(32'h0C, 32'h000, 32'h006, 16'h0008, 16'h000C);
    chk(32'(hiB), P);
    chk(32'(loB), 1);
    // Down mode reloads period after zero; widths differ from up mode on purpose
    setup(32'h0D, 32'h000, 32'h006, 16'h0008, 16'h000C);
    chk(32'(hiB), 1);
    chk(32'(loB), P);
  endtask
  // Divide by two: every width doubles, B toggles once per cycle at zero
  task automatic t_div();
    setup(32'h1E, 32'h060, 32'h003, 16'h0008, 16'h000C);
    repeat (10 * P) @(posedge mclk);
    chk(32'(hiA + loA), 4 * P);
    chk(32'(loA), 32);
    chk(32'(hiB), 4 * P);
    chk(32'(loB), 4 * P);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {mclk, psel, penable, pwrite} = 4'h0;
    rst = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {err_total, n_checks, cycles} = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_sym();
    t_shadow();
    t_asym();
    t_up();
    t_div();
    complete_run();
  end
endmodule // tb
